/* verilog/dacie_defines.svh */
// register map, field positions and reset values of the dac interrupt
// enable pair; included by the design and the bench by bare name
`ifndef DACIE_DEFINES_SVH
`define DACIE_DEFINES_SVH

// register indices; byte address is four times the index
`define DACIE_IDX_CLR      8'h04
`define DACIE_IDX_SET      8'h05
`define DACIE_IDX_FLAG     8'h06

// field positions inside the enable and flag registers
`define DACIE_BIT_UNDERRUN 0
`define DACIE_BIT_EMPTY    1

// reset values
`define DACIE_IE_RST       2'h0
`define DACIE_FLAG_RST     2'h0
`define DACIE_RDATA_RST    32'h0000_0000

`endif

/* verilog/dacie_pkg.sv */
// types shared by the dac interrupt enable pair and its bench
// assumes nothing of its surroundings
`default_nettype none

package dacie_pkg;

  // ahb-lite transfer type
  typedef enum logic [1:0] {
    DACIE_IDLE   = 2'b00,
    DACIE_BUSY   = 2'b01,
    DACIE_NONSEQ = 2'b10,
    DACIE_SEQ    = 2'b11
  } dacie_htrans_t;

  // two interrupt sources, one bit each
  typedef logic [1:0] dacie_irq_vec_t;

endpackage : dacie_pkg

`default_nettype wire

/* verilog/dacie_top.sv */
// interrupt enable set/clear pair of a dac, with its flag register and
// the single interrupt line, reached as an ahb-lite slave
// assumes one clock, a synchronous low reset and event pulses one cycle long
//
// The AHB-Lite register port was chosen for this implementation.
`default_nettype none

`include "dacie_defines.svh"

module dacie_top
  import dacie_pkg::*;
(
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  // interrupt sources and request
  input  wire logic        i_evt_empty,
  input  wire logic        i_evt_underrun,
  output logic             o_irq
);

  // every property below runs on the bus clock and, except a_reset_zero, rests during reset
  default clocking cb_prop @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  // ----------------------------------------------------------------
  // address phase decode
  // ----------------------------------------------------------------
  logic           acc;
  logic           addr_ok;
  logic [7:0]     addr_idx;
  dacie_htrans_t  trans;

  assign trans    = dacie_htrans_t'(i_htrans);
  assign addr_idx = i_haddr[9:2];
  assign addr_ok  = (i_haddr[31:10] == 22'h00_0000) &&
                    (i_haddr[1:0] == 2'h0);
  // whole-word singles only; hsize is not checked, narrower writes
  // still act on the low lanes of hwdata
  assign acc = i_hsel && i_hready && trans[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dacie_irq_vec_t ie;
  dacie_irq_vec_t flag;
  logic           wr_pend;
  logic [7:0]     wr_idx;
  logic           rd_pend;
  logic [7:0]     rd_idx;
  logic [31:0]    hrdata;
  logic           irq;

  dacie_irq_vec_t next_ie;
  dacie_irq_vec_t next_flag;
  logic           next_wr_pend;
  logic [7:0]     next_wr_idx;
  logic           next_rd_pend;
  logic [7:0]     next_rd_idx;
  logic [31:0]    next_hrdata;
  logic           next_irq;

  dacie_irq_vec_t evt;
  dacie_irq_vec_t set_mask;
  dacie_irq_vec_t clr_mask;
  dacie_irq_vec_t rd_clr;

  assign evt[`DACIE_BIT_EMPTY]    = i_evt_empty;
  assign evt[`DACIE_BIT_UNDERRUN] = i_evt_underrun;

  // ----------------------------------------------------------------
  // enable store and flags
  // ----------------------------------------------------------------
  // one copy of the enable and flag logic per interrupt source
  for (genvar g = 0; g < 2; g++) begin : g_src
    always_comb begin
      // one store behind both registers; set and clear sit at separate
      // addresses, so they can never collide in one cycle
      next_ie[g]   = (ie[g] | set_mask[g]) & ~clr_mask[g];
      // an event in the cycle of a clearing read wins, so none is lost
      next_flag[g] = (flag[g] & ~rd_clr[g]) | evt[g];
    end
  end

  // ----------------------------------------------------------------
  // bus pipeline: address phase captured, data phase acted on
  // ----------------------------------------------------------------
  // the slave never stalls, so each data phase lasts exactly one cycle
  // and a write lands at the edge that ends it
  always_comb begin
    next_wr_pend = acc && i_hwrite && addr_ok;
    next_wr_idx  = addr_idx;
    next_rd_pend = acc && !i_hwrite;
    next_rd_idx  = addr_ok ? addr_idx : 8'hFF;
    set_mask     = 2'h0;
    clr_mask     = 2'h0;
    // writes take effect in the data phase, where hwdata stands
    if (wr_pend && wr_idx == `DACIE_IDX_SET) begin
      set_mask = i_hwdata[1:0];
    end
    if (wr_pend && wr_idx == `DACIE_IDX_CLR) begin
      clr_mask = i_hwdata[1:0];
    end
    // a flag read clears in the address phase; its data is taken first
    rd_clr = (next_rd_pend && next_rd_idx == `DACIE_IDX_FLAG) ?
             2'h3 : 2'h0;
  end

  // ----------------------------------------------------------------
  // read data and request
  // ----------------------------------------------------------------
  // read data built from the next enables so that a write just ahead
  // of the read is already seen
  always_comb begin
    unique case (next_rd_idx)
      `DACIE_IDX_SET,
      `DACIE_IDX_CLR:  next_hrdata = {30'h0000_0000, next_ie};
      `DACIE_IDX_FLAG: next_hrdata = {30'h0000_0000, flag};
      default:         next_hrdata = 32'h0000_0000;
    endcase
    if (!next_rd_pend) begin
      next_hrdata = 32'h0000_0000;
    end
    // registered request follows next flags and enables
    next_irq = |(next_flag & next_ie);
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ie          <= `DACIE_IE_RST;
      flag        <= `DACIE_FLAG_RST;
      wr_pend     <= 1'b0;
      wr_idx      <= 8'h00;
      rd_pend     <= 1'b0;
      rd_idx      <= 8'h00;
      hrdata      <= `DACIE_RDATA_RST;
      irq         <= 1'b0;
      o_hreadyout <= 1'b0;
    end else begin
      ie          <= next_ie;
      flag        <= next_flag;
      wr_pend     <= next_wr_pend;
      wr_idx      <= next_wr_idx;
      rd_pend     <= next_rd_pend;
      rd_idx      <= next_rd_idx;
      hrdata      <= next_hrdata;
      irq         <= next_irq;
      // zero wait states; low during reset and in the first cycle after it
      o_hreadyout <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_hrdata = hrdata;
  assign o_irq    = irq;

  always_ff @(posedge i_mclk) begin
    // every answer is okay, unmapped addresses included
    o_hresp <= 1'b0;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic set_wr;
  logic clr_wr;
  assign set_wr = wr_pend && wr_idx == `DACIE_IDX_SET;
  assign clr_wr = wr_pend && wr_idx == `DACIE_IDX_CLR;

  a_set_empty: assert property (
    set_wr && i_hwdata[`DACIE_BIT_EMPTY] |=> ie[`DACIE_BIT_EMPTY])
    else $error("empty enable not set by write one");

  a_set_underrun: assert property (
    set_wr && i_hwdata[`DACIE_BIT_UNDERRUN] |=> ie[`DACIE_BIT_UNDERRUN])
    else $error("underrun enable not set by write one");

  a_clr_empty: assert property (
    clr_wr && i_hwdata[`DACIE_BIT_EMPTY] |=> !ie[`DACIE_BIT_EMPTY])
    else $error("empty enable not cleared by write one");

  a_clr_underrun: assert property (
    clr_wr && i_hwdata[`DACIE_BIT_UNDERRUN] |=> !ie[`DACIE_BIT_UNDERRUN])
    else $error("underrun enable not cleared by write one");

  a_zero_keeps: assert property (
    !(set_wr || clr_wr) || i_hwdata[1:0] == 2'h0 |=> $stable(ie))
    else $error("enable changed without a one written");

  // a set write may only add enables, a clear write may only remove them
  a_set_only_sets: assert property (
    set_wr |=> ($past(ie) & ~ie) == 2'h0)
    else $error("set write removed an enable");

  a_clr_only_clears: assert property (
    clr_wr |=> (ie & ~$past(ie)) == 2'h0)
    else $error("clear write added an enable");

  a_shared_read: assert property (
    rd_pend && (rd_idx == `DACIE_IDX_SET || rd_idx == `DACIE_IDX_CLR)
      |-> o_hrdata == {30'h0000_0000, ie})
    else $error("enable read does not show the shared store");

  // reset itself must be watched here, so this one is never disabled
  a_reset_zero: assert property (
    disable iff (1'b0)
    $rose(i_rst_n) |-> ie == 2'h0 && !o_irq ##1 o_hreadyout)
    else $error("enables not zero after reset");

  a_irq_level: assert property (
    o_irq == |(flag & ie))
    else $error("interrupt line disagrees with flags and enables");

  a_flag_sticky: assert property (
    i_evt_empty |=> flag[`DACIE_BIT_EMPTY])
    else $error("empty event lost");

  a_under_sticky: assert property (
    i_evt_underrun |=> flag[`DACIE_BIT_UNDERRUN])
    else $error("underrun event lost");

  // after a flag read only the events of the address cycle remain
  a_read_clears: assert property (
    rd_pend && rd_idx == `DACIE_IDX_FLAG |-> flag == $past(evt))
    else $error("flag read did not clear the flags");

  a_flag_data: assert property (
    rd_pend && rd_idx == `DACIE_IDX_FLAG
      |-> o_hrdata == {30'h0000_0000, $past(flag)})
    else $error("flag read returned the wrong value");

  a_rdata_idle: assert property (
    !rd_pend |-> o_hrdata == 32'h0000_0000)
    else $error("read data not zero outside a read");

  // no wait states: ready is high from the second cycle after reset on
  a_ready_high: assert property (
    $past(i_rst_n) |-> o_hreadyout)
    else $error("ready low outside reset");

  a_resp_okay: assert property (
    !o_hresp)
    else $error("error response given");

  // main scenarios worth seeing at least once
  c_irq_rise: cover property (
    $rose(o_irq));
  c_irq_by_clr: cover property (
    clr_wr && o_irq ##1 !o_irq);
  c_flag_read: cover property (
    rd_pend && rd_idx == `DACIE_IDX_FLAG && o_hrdata[1:0] != 2'h0);
  c_event_wins: cover property (
    rd_clr[`DACIE_BIT_EMPTY] && evt[`DACIE_BIT_EMPTY]);
  c_set_both: cover property (
    set_wr && i_hwdata[1:0] == 2'h3);

endmodule : dacie_top

`default_nettype wire

/* tb/dacie_top_tb.sv */
// self-checking bench of the dac interrupt enable pair
// assumes the design files are compiled first; the bench is the bus master
`default_nettype none
`include "dacie_defines.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end

module dacie_top_tb import dacie_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] a; logic [31:0] d; logic [1:0] e;} dacie_row_t;
  localparam logic [31:0] a_clr  = {22'h0, `DACIE_IDX_CLR, 2'h0};
  localparam logic [31:0] a_set  = {22'h0, `DACIE_IDX_SET, 2'h0};
  localparam logic [31:0] a_flag = {22'h0, `DACIE_IDX_FLAG, 2'h0};
  localparam logic [31:0] a_bad  = 32'h20;
  logic        i_mclk, i_rst_n, i_hsel, i_hwrite, i_evt_empty, i_evt_underrun;
  logic [31:0] i_haddr, i_hwdata, rd;
  logic [1:0]  i_htrans;
  logic [2:0]  i_hsize;
  wire logic   o_hreadyout, o_hresp, o_irq;
  wire logic [31:0] o_hrdata;
  int          bad_count, compares;
  // zero bits leave the store alone, so a row may reuse an earlier state
  dacie_row_t  rows [9] = '{'{a_set, 32'h2, 2'h2}, '{a_set, 32'h1, 2'h3},
    '{a_set, 32'h0, 2'h3}, '{a_clr, 32'h0, 2'h3}, '{a_clr, 32'h2, 2'h1},
    '{a_set, 32'h2, 2'h3}, '{a_clr, 32'h1, 2'h2},
    '{a_clr, 32'hFFFF_FFFF, 2'h0}, '{a_bad, 32'h3, 2'h0}};

  dacie_top dacie_top_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
    .i_evt_empty(i_evt_empty), .i_evt_underrun(i_evt_underrun), .o_irq(o_irq));

  // ----------------------------------------------------------------
  // bus and event tasks
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [31:0] a, d);
    i_haddr <= a;
    i_hwrite <= w;
    i_htrans <= DACIE_NONSEQ;
    do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
    i_htrans <= DACIE_IDLE;
    i_hwdata <= d;
    do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
  endtask : xfer

  task automatic pulse(input logic [1:0] v);
    {i_evt_empty, i_evt_underrun} <= v;
    @(posedge i_mclk);
    {i_evt_empty, i_evt_underrun} <= 2'h0;
    @(posedge i_mclk);
  endtask : pulse

  task automatic end_sim();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  // the whole run needs about a hundred cycles; hangs stop well past that
  initial begin
    repeat (3000) @(posedge i_mclk);
    bad_count++;
    end_sim();
  end

  initial begin
    {i_rst_n, i_hsel, i_hwrite, i_evt_empty, i_evt_underrun} = 5'h08;
    {i_haddr, i_hwdata, i_htrans, i_hsize} = {64'h0, DACIE_IDLE, 3'h2};
    repeat (16) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    xfer(1'b0, a_set, 32'h0);
    `CHK(rd, 32'h0)
    xfer(1'b0, a_bad, 32'h0);
    `CHK(rd, 32'h0)
    $display("reset test done");
    foreach (rows[k]) begin
      xfer(1'b1, rows[k].a, rows[k].d);
      xfer(1'b0, a_set, 32'h0);
      `CHK(rd, {30'h0, rows[k].e})
      xfer(1'b0, a_clr, 32'h0);
      `CHK(rd, {30'h0, rows[k].e})
    end
    `CHK(o_hresp, 1'b0)
    $display("row test done");
    pulse(2'h3);
    `CHK(o_irq, 1'b0)
    xfer(1'b0, a_flag, 32'h0);
    `CHK(rd, 32'h3)
    xfer(1'b1, a_set, 32'h2);
    pulse(2'h1);
    `CHK(o_irq, 1'b0)
    pulse(2'h2);
    `CHK(o_irq, 1'b1)
    xfer(1'b1, a_clr, 32'h2);
    @(posedge i_mclk);
    `CHK(o_irq, 1'b0)
    xfer(1'b1, a_set, 32'h2);
    @(posedge i_mclk);
    `CHK(o_irq, 1'b1)
    xfer(1'b0, a_flag, 32'h0);
    @(posedge i_mclk);
    `CHK(o_irq, 1'b0)
    fork
      xfer(1'b0, a_flag, 32'h0);
      pulse(2'h2);
    join
    `CHK(rd, 32'h0)
    `CHK(o_irq, 1'b1)
    xfer(1'b0, a_flag, 32'h0);
    `CHK(rd, 32'h2)
    $display("irq test done");
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    `CHK(o_hreadyout, 1'b0)
    i_rst_n <= 1'b1;
    xfer(1'b0, a_set, 32'h0);
    `CHK(rd, 32'h0)
    $display("second reset test done");
    end_sim();
  end
endmodule : dacie_top_tb
`default_nettype wire
